// File: rtl/pwm_timer_pkg.sv
// Constants for the center-aligned pwm timer block
package pwm_timer_pkg;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam int PS_W = 3;
    localparam int ADDR_W = 12;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CNT_HI = 12'h004;
    localparam logic [11:0] OFF_CNT_LO = 12'h008;
    localparam logic [11:0] OFF_MOD_HI = 12'h00C;
    localparam logic [11:0] OFF_MOD_LO = 12'h010;
    localparam logic [11:0] OFF_CH_BASE = 12'h020;
    localparam logic [11:0] OFF_CH_STRIDE = 12'h008;
    localparam logic [11:0] OFF_CH_LO = 12'h004;
    // Control register fields
    localparam int CTRL_PS_LSB = 0;
    localparam int CTRL_EN_BIT = 3;
    localparam int CTRL_CPWM_BIT = 4;
    localparam int CTRL_UP_BIT = 5;
    localparam int CTRL_POL_LSB = 8;
    // Reset values, counter step and read default
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] CHV_RST = 16'h0000;
    localparam logic [2:0] PS_RST = 3'h0;
    localparam logic [6:0] DIV_RST = 7'h00;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : pwm_timer_pkg

// File: rtl/pwm_prescaler.sv
// Free-running prescaler producing one-cycle count ticks
`timescale 1ns/1ps
module pwm_prescaler
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] prescale_select_i,
    // Tick out
    output logic            tick_o
);
    logic [6:0] div_q;
    logic [6:0] div_d;
    logic [7:0] mask;
    logic       hit;

    // Divider stages are never cleared on a select change
    assign div_d = run_i ? div_q + 7'h01 : div_q;
    // Ratio is 2^code: code 0 divides by one, code 1 by two
    assign mask = (8'h01 << prescale_select_i) - 8'h01;
    assign hit = run_i && ((div_q & mask[6:0]) == mask[6:0]);

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            div_q  <= pwm_timer_pkg::DIV_RST;
            tick_o <= 1'b0;
        end
        else
        begin
            div_q  <= div_d;
            tick_o <= hit;
        end
    end
endmodule : pwm_prescaler

// File: rtl/center_aligned_pwm_timer.sv
// Center-aligned pwm timer with APB register access
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module center_aligned_pwm_timer
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Channel pins
    output logic [1:0]       pwm_o
);
    localparam int NCH = pwm_timer_pkg::NUM_CH;

    logic [15:0] counter_value_q;
    logic [15:0] counter_value_d;
    logic [15:0] modulo_value_q;
    logic [2:0]  prescale_select_q;
    logic        run_q;
    logic        cpwm_q;
    logic        down_q;
    logic        down_d;
    logic [NCH-1:0] pol_q;
    logic [15:0] chv_q [NCH];
    logic [NCH-1:0] out_q;
    logic [7:0]  cnt_hi_latch_q;
    logic [7:0]  chv_hi_buf_q [NCH];
    logic [7:0]  mod_hi_buf_q;
    logic        tick;
    logic        at_mod;
    logic        at_zero;

    // Bus decode
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic [NCH-1:0] ch_hi_sel;
    logic [NCH-1:0] ch_lo_sel;

    function automatic logic [11:0] ch_addr(input int idx,
                                            input logic lo);
        logic [11:0] base;
        base = pwm_timer_pkg::OFF_CH_BASE
             + 12'(idx) * pwm_timer_pkg::OFF_CH_STRIDE;
        ch_addr = lo ? base + pwm_timer_pkg::OFF_CH_LO : base;
    endfunction : ch_addr

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    pwm_prescaler u_prescaler
    (
        .sys_clk_i         (sys_clk_i),
        .nrst_i            (nrst_i),
        .run_i             (run_q),
        .prescale_select_i (prescale_select_q),
        .tick_o            (tick)
    );

    // Counter direction and wrap
    // Period boundary is the up-count arrival at modulo, where the
    // direction turns; the pulse is then centred on the zero count
    assign at_mod  = counter_value_q == modulo_value_q;
    assign at_zero = counter_value_q == pwm_timer_pkg::CNT_RST;

    always_comb
    begin
        counter_value_d = counter_value_q;
        down_d = down_q;
        if (tick)
        begin
            if (cpwm_q)
            begin
                // Reversal happens on the tick after each end value,
                // so zero and modulo each last one tick
                if (!down_q && at_mod)
                begin
                    down_d = 1'b1;
                    counter_value_d = counter_value_q - pwm_timer_pkg::CNT_ONE;
                end
                else if (down_q && at_zero)
                begin
                    down_d = 1'b0;
                    counter_value_d = counter_value_q + pwm_timer_pkg::CNT_ONE;
                end
                else if (down_q)
                    counter_value_d = counter_value_q - pwm_timer_pkg::CNT_ONE;
                else
                    counter_value_d = counter_value_q + pwm_timer_pkg::CNT_ONE;
            end
            else
            begin
                down_d = 1'b0;
                counter_value_d = at_mod ? pwm_timer_pkg::CNT_RST
                    : counter_value_q + pwm_timer_pkg::CNT_ONE;
            end
        end
    end

    // Output flops per channel
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        logic match;
        logic neg;
        logic broken;
        logic act_lvl;
        assign match = chv_q[c] == counter_value_q;
        assign neg = chv_q[c][pwm_timer_pkg::CNT_W-1];
        // Silicon shows zero duty at modulo and modulo-1
        assign broken = (chv_q[c] == modulo_value_q)
            || (chv_q[c] + pwm_timer_pkg::CNT_ONE == modulo_value_q);
        assign act_lvl = !pol_q[c];
        assign ch_hi_sel[c] = paddr_i == ch_addr(c, 1'b0);
        assign ch_lo_sel[c] = paddr_i == ch_addr(c, 1'b1);

        always_ff @(posedge sys_clk_i)
        begin
            if (!nrst_i)
                out_q[c] <= 1'b0;
            else if (tick && cpwm_q)
            begin
                // Only a compare event or a negative or zero-duty value moves the flop; start at zero
                // is mid-period so first half period looks idle
                if (neg || broken)
                    out_q[c] <= ~act_lvl;
                else if (match)
                    out_q[c] <= down_q ? act_lvl : ~act_lvl;
            end
            else if (tick && !cpwm_q)
            begin
                // Edge mode uses the live value; a zero-to-nonzero
                // write may miss the boundary and lag a period
                if (at_mod && chv_q[c] != pwm_timer_pkg::CHV_RST)
                    out_q[c] <= act_lvl;
                else if (match)
                    out_q[c] <= ~act_lvl;
            end
        end
    end

    // Read mux; output flops are not readable
    always_comb
    begin
        rd_data = pwm_timer_pkg::RD_ZERO;
        rd_hit = 1'b1;
        if (paddr_i == pwm_timer_pkg::OFF_CTRL)
        begin
            rd_data[pwm_timer_pkg::CTRL_PS_LSB +: 3] = prescale_select_q;
            rd_data[pwm_timer_pkg::CTRL_EN_BIT] = run_q;
            rd_data[pwm_timer_pkg::CTRL_CPWM_BIT] = cpwm_q;
            rd_data[pwm_timer_pkg::CTRL_UP_BIT] = !down_q;
            rd_data[pwm_timer_pkg::CTRL_POL_LSB +: NCH] = pol_q;
        end
        else if (paddr_i == pwm_timer_pkg::OFF_CNT_HI)
            rd_data[7:0] = counter_value_q[15:8];
        else if (paddr_i == pwm_timer_pkg::OFF_CNT_LO)
            rd_data[7:0] = cnt_hi_latch_q;
        else if (paddr_i == pwm_timer_pkg::OFF_MOD_HI)
            rd_data[7:0] = modulo_value_q[15:8];
        else if (paddr_i == pwm_timer_pkg::OFF_MOD_LO)
            rd_data[7:0] = modulo_value_q[7:0];
        else
        begin
            rd_hit = 1'b0;
            for (int i = 0; i < NCH; i++)
            begin
                if (ch_hi_sel[i])
                begin
                    rd_data[7:0] = chv_q[i][15:8];
                    rd_hit = 1'b1;
                end
                else if (ch_lo_sel[i])
                begin
                    rd_data[7:0] = chv_q[i][7:0];
                    rd_hit = 1'b1;
                end
            end
        end
    end

    // Registers and bus answer
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            counter_value_q   <= pwm_timer_pkg::CNT_RST;
            modulo_value_q    <= pwm_timer_pkg::MOD_RST;
            prescale_select_q <= pwm_timer_pkg::PS_RST;
            run_q             <= 1'b0;
            cpwm_q            <= 1'b0;
            down_q            <= 1'b0;
            pol_q             <= '0;
            cnt_hi_latch_q    <= '0;
            mod_hi_buf_q      <= '0;
            pready_o          <= 1'b0;
            pslverr_o         <= 1'b0;
            prdata_o          <= pwm_timer_pkg::RD_ZERO;
            for (int i = 0; i < NCH; i++)
            begin
                chv_q[i]        <= pwm_timer_pkg::CHV_RST;
                chv_hi_buf_q[i] <= '0;
            end
        end
        else
        begin
            counter_value_q <= counter_value_d;
            down_q <= down_d;
            // No wait state: answer lands on the first access cycle
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !rd_hit;
            if (rd_en)
                prdata_o <= rd_data;
            // Reading the high byte freezes the low byte for a
            // coherent 16-bit read
            if (rd_en && paddr_i == pwm_timer_pkg::OFF_CNT_HI)
                cnt_hi_latch_q <= counter_value_q[7:0];
            if (wr_en && pready_o)
            begin
                if (paddr_i == pwm_timer_pkg::OFF_CTRL)
                begin
                    prescale_select_q <=
                        pwdata_i[pwm_timer_pkg::CTRL_PS_LSB +: 3];
                    run_q  <= pwdata_i[pwm_timer_pkg::CTRL_EN_BIT];
                    cpwm_q <= pwdata_i[pwm_timer_pkg::CTRL_CPWM_BIT];
                    pol_q  <= pwdata_i[pwm_timer_pkg::CTRL_POL_LSB +: NCH];
                end
                else if (paddr_i == pwm_timer_pkg::OFF_CNT_HI
                      || paddr_i == pwm_timer_pkg::OFF_CNT_LO)
                    counter_value_q <= pwm_timer_pkg::CNT_RST;
                else if (paddr_i == pwm_timer_pkg::OFF_MOD_HI)
                    mod_hi_buf_q <= pwdata_i[7:0];
                else if (paddr_i == pwm_timer_pkg::OFF_MOD_LO)
                    modulo_value_q <= {mod_hi_buf_q, pwdata_i[7:0]};
                for (int i = 0; i < NCH; i++)
                begin
                    if (ch_hi_sel[i])
                        chv_hi_buf_q[i] <= pwdata_i[7:0];
                    else if (ch_lo_sel[i])
                        chv_q[i] <= {chv_hi_buf_q[i], pwdata_i[7:0]};
                end
            end
        end
    end

    assign pwm_o = out_q;
endmodule : center_aligned_pwm_timer

// File: testbench/pwm_timer_chk.sv
// Bus and pin checker for the center-aligned pwm timer
`timescale 1ns/1ps
module pwm_timer_chk
(
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    // APB side
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Channel pins
    input wire logic [1:0]  pwm_o
);
    wire logic mapped_w;

    // Word-aligned control, counter, modulo and two channel pairs
    assign mapped_w = (paddr_i[1:0] == 2'h0)
        && (paddr_i <= 12'h010 || (paddr_i >= 12'h020 && paddr_i <= 12'h02C));

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    property p_rst_low;
        $rose(nrst_i) |-> pwm_o == 2'h0 ##1 pwm_o == 2'h0;
    endproperty
    property p_answer;
        s_setup ##1 s_access |-> pready_o;
    endproperty
    property p_one;
        pready_o |=> !pready_o;
    endproperty
    property p_cause;
        pready_o |-> psel_i && penable_i && $past(psel_i && !penable_i);
    endproperty
    property p_err_dec;
        pready_o |-> pslverr_o == !mapped_w;
    endproperty
    property p_err_only;
        pslverr_o |-> pready_o;
    endproperty
    property p_err_rd;
        pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000;
    endproperty
    property p_rst_bus;
        $rose(nrst_i) |-> !pready_o && !pslverr_o;
    endproperty

    a_rst_low: assert property (p_rst_low)
        else $error("pin not low after reset");
    a_answer: assert property (p_answer)
        else $error("no ready in first access cycle");
    a_one: assert property (p_one)
        else $error("ready longer than one cycle");
    a_cause: assert property (p_cause)
        else $error("ready without setup and access");
    a_err_dec: assert property (p_err_dec)
        else $error("error flag disagrees with address map");
    a_err_only: assert property (p_err_only)
        else $error("error flag without ready");
    a_err_rd: assert property (p_err_rd)
        else $error("unmapped read data not zero");
    a_rst_bus: assert property (p_rst_bus)
        else $error("bus answer active after reset");
endmodule : pwm_timer_chk

bind center_aligned_pwm_timer pwm_timer_chk pwm_timer_chk_i
(
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .pwm_o     (pwm_o)
);

// File: testbench/tb.sv
// Self-checking bench for the center-aligned pwm timer
`timescale 1ns/1ps
module tb;
    logic        sys_clk_i;
    logic        nrst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [1:0]  pwm_o;
    logic [31:0] seed_q;
    logic [31:0] rd;
    logic        er;
    logic [15:0] v;
    int          fails;
    int          tests_run;
    int          hi;
    int          per;
    int          n;
    int          m;
    int          c;

    center_aligned_pwm_timer center_aligned_pwm_timer_i
    (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .pwm_o     (pwm_o)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction : rnd

    // Pulse 2*value ticks, period 2*modulo ticks, one tick per 2^code clocks
    function automatic int ticks(input int x, input int code);
        return (2 * x) << code;
    endfunction : ticks

    // Edge mode: pin set at the wrap, cleared at the tick on the value,
    // so pulse and period each carry one extra tick
    function automatic int edge_ticks(input int x);
        return x + 1;
    endfunction : edge_ticks

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Idle cycle after each transfer keeps drivers to one change per step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (pready_o !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            fails++;
            report_and_stop();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : apb

    // High byte is buffered, low byte commits the value
    task automatic wr16(input logic [11:0] a, input logic [15:0] x);
        apb(1'b1, a, {24'h00_0000, x[15:8]});
        apb(1'b1, a + 12'h004, {24'h00_0000, x[7:0]});
    endtask : wr16

    task automatic rd16(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
        v[15:8] = rd[7:0];
        apb(1'b0, a + 12'h004, 32'h0000_0000);
        v[7:0] = rd[7:0];
    endtask : rd16

    task automatic wait_lvl(input int ch, input logic l, output int k);
        k = 0;
        while (pwm_o[ch] !== l && k < 20000)
        begin
            @(posedge sys_clk_i);
            k++;
        end
        if (k >= 20000)
        begin
            fails++;
            report_and_stop();
        end
    endtask : wait_lvl

    task automatic meas(input int ch);
        wait_lvl(ch, 1'b0, n);
        wait_lvl(ch, 1'b1, n);
        wait_lvl(ch, 1'b0, hi);
        wait_lvl(ch, 1'b1, n);
        per = hi + n;
    endtask : meas

    task automatic hicount(input int ch, input int len);
        hi = 0;
        repeat (len)
        begin
            @(posedge sys_clk_i);
            if (pwm_o[ch] === 1'b1)
                hi++;
        end
    endtask : hicount

    initial
    begin
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        fails = 0;
        tests_run = 0;
        seed_q = 32'h0000_6C9C;
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        chk({30'h0, pwm_o}, 32'h0000_0000);
        rd16(12'h004);
        chk(v, 16'h0000);
        rd16(12'h00C);
        chk(v, 16'hFFFF);
        apb(1'b1, 12'h014, 32'h0000_00A5);
        chk(er, 1'b1);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test reset and map done");
        m = 5 + rnd() % 4;
        c = 1 + rnd() % (m - 2);
        wr16(12'h00C, m[15:0]);
        wr16(12'h020, c[15:0]);
        wr16(12'h028, m[15:0]);
        // First period after a prescale change may be off, so it is skipped
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 12'h000, 32'h0000_0018 | k);
            meas(0);
            meas(0);
            chk(hi, ticks(c, k));
            chk(per, ticks(m, k));
        end
        $display("Test prescale and period done");
        apb(1'b1, 12'h000, 32'h0000_0018);
        for (int k = 0; k < 3; k++)
        begin
            v = (k == 0) ? m[15:0] : (k == 1) ? m[15:0] - 16'h0001
                : 16'h8000 | 16'(rnd());
            wr16(12'h028, v);
            hicount(1, 8 * m);
            chk(hi, 0);
        end
        $display("Test zero duty cases done");
        apb(1'b1, 12'h000, 32'h0000_0008);
        meas(0);
        meas(0);
        chk(hi, edge_ticks(c));
        chk(per, edge_ticks(m));
        $display("Test edge mode done");
        wait_lvl(0, 1'b1, n);
        apb(1'b1, 12'h000, 32'h0000_0010);
        // A tick issued before the stop may still move the pin here
        @(posedge sys_clk_i);
        c = pwm_o[0];
        hicount(0, 50);
        chk(hi, 50 * c);
        apb(1'b1, 12'h000, 32'h0000_0018);
        wait_lvl(0, 1'b1, n);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk({30'h0, pwm_o}, 32'h0000_0000);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        rd16(12'h004);
        chk(v, 16'h0000);
        $display("Test hold and reset done");
        report_and_stop();
    end
endmodule : tb
